//--- spcr_top.sv
// spi slave holding serial port configuration, identity and readback registers
`timescale 1ns/100ps
module spcr_top #(
    parameter logic [7:0] REVISION = 8'h11,  // arbitrary value
    parameter logic [7:0] VARIANT = 8'h5a    // arbitrary value
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdio,
    input wire logic i_i2c_mode,
    input wire logic i_update,
    output logic o_sdio,
    output logic o_sdio_oe,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    output logic o_direction_select_bit,
    output logic o_lsb_first,
    output logic [7:0] o_active_user0,
    output logic o_busy
);
    typedef enum logic [1:0] {ST_HDR, ST_WR, ST_RD} spcr_state_t;

    // link domain: everything below up to the core status block runs on i_sclk, cs high acts as frame reset
    spcr_state_t state_q;
    logic [4:0] cnt_q;
    logic [15:0] hdr_q;
    logic [7:0] sh_q;
    logic [12:0] addr_q;
    logic [7:0] config_q;
    logic [7:0] readback_q;
    logic [7:0] user0_q;
    logic [7:0] user1_q;
    logic [7:0] act_user0_q;
    logic [7:0] act_user1_q;
    logic soft_pend_q;
    logic [1:0] rst_sync_q;
    logic link_rst;
    logic [2:0] upd_sync_q;
    logic [1:0] i2c_sync_q;
    logic lsb_eff;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;

    // i2c mode and update come from the core side; two flops into sclk domain for i2c mode, three for update
    always_ff @(posedge i_sclk) begin
        i2c_sync_q <= {i2c_sync_q[0], i_i2c_mode};
        upd_sync_q <= {upd_sync_q[1:0], i_update};
    end

    // reset is core-timed too; link logic sees it two sclk edges late
    always_ff @(posedge i_sclk) begin
        rst_sync_q <= {rst_sync_q[0], i_rst};
    end
    assign link_rst = rst_sync_q[1];

    assign lsb_eff = config_q[spcr_pkg::BIT_LSB_FIRST] & ~i2c_sync_q[1];

    function automatic logic [7:0] spcr_rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) begin
            spcr_rev8[k] = v[7 - k];
        end
    endfunction

    function automatic logic [7:0] spcr_read(input logic [12:0] a, input logic act,
            input logic [7:0] cfg, input logic [7:0] rb, input logic [7:0] b0,
            input logic [7:0] b1, input logic [7:0] a0, input logic [7:0] a1);
        unique case (a)
            spcr_pkg::ADDR_CONFIG: spcr_read = cfg;
            spcr_pkg::ADDR_REVISION: spcr_read = REVISION;
            spcr_pkg::ADDR_VARIANT: spcr_read = VARIANT;
            spcr_pkg::ADDR_READBACK: spcr_read = rb;
            spcr_pkg::ADDR_USER0: spcr_read = act ? a0 : b0;
            spcr_pkg::ADDR_USER1: spcr_read = act ? a1 : b1;
            default: spcr_read = 8'h00;
        endcase
    endfunction

    assign rd_byte = spcr_read(addr_q, readback_q[spcr_pkg::BIT_READBACK], config_q,
        readback_q, user0_q, user1_q, act_user0_q, act_user1_q);
    // assembled incoming byte; bit order follows the order bit outside i2c mode
    assign wr_byte = lsb_eff ? {i_sdio, sh_q[7:1]} : {sh_q[6:0], i_sdio};

    // header: r/w bit, two length bits, 13 address bits, always msb first
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            state_q <= ST_HDR;
            cnt_q <= 5'h00;
            hdr_q <= 16'h0000;
            sh_q <= 8'h00;
            addr_q <= 13'h0000;
        end else begin
            unique case (state_q)
                ST_HDR: begin
                    hdr_q <= {hdr_q[14:0], i_sdio};
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h0f) begin
                        cnt_q <= 5'h00;
                        addr_q <= {hdr_q[11:0], i_sdio};
                        state_q <= hdr_q[14] ? ST_RD : ST_WR;
                    end
                end
                ST_WR, ST_RD: begin
                    sh_q <= wr_byte;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07) begin
                        cnt_q <= 5'h00;
                        if (lsb_eff) begin
                            addr_q <= addr_q + 13'h0001;
                        end else begin
                            addr_q <= addr_q - 13'h0001;
                        end
                    end
                end
                default: state_q <= ST_HDR;
            endcase
        end
    end

    logic wr_done;
    assign wr_done = (state_q == ST_WR) && (cnt_q == 5'h07);

    // configuration register survives soft reset; soft bit and its mirror clear next sclk
    always_ff @(posedge i_sclk) begin
        if (link_rst) begin
            config_q <= spcr_pkg::CONFIG_RESET;
            soft_pend_q <= 1'b0;
        end else begin
            soft_pend_q <= 1'b0;
            if (soft_pend_q) begin
                config_q[spcr_pkg::BIT_SOFT_RESET] <= 1'b0;
                config_q[7 - spcr_pkg::BIT_SOFT_RESET] <= 1'b0;
            end
            if (wr_done && addr_q == spcr_pkg::ADDR_CONFIG) begin
                // mirror nibble is kept as written; host keeps it consistent
                config_q <= wr_byte;
                soft_pend_q <= wr_byte[spcr_pkg::BIT_SOFT_RESET];
            end
        end
    end

    // buffer registers and their active copies
    always_ff @(posedge i_sclk) begin
        if (link_rst || soft_pend_q) begin
            readback_q <= spcr_pkg::READBACK_RESET;
            user0_q <= spcr_pkg::USER_RESET;
            user1_q <= spcr_pkg::USER_RESET;
            act_user0_q <= spcr_pkg::USER_RESET;
            act_user1_q <= spcr_pkg::USER_RESET;
        end else begin
            if (wr_done) begin
                unique case (addr_q)
                    spcr_pkg::ADDR_READBACK: readback_q <= {7'h00, wr_byte[0]};
                    spcr_pkg::ADDR_USER0: user0_q <= wr_byte;
                    spcr_pkg::ADDR_USER1: user1_q <= wr_byte;
                    default: ;
                endcase
            end
            if (upd_sync_q[2] != upd_sync_q[1]) begin
                act_user0_q <= user0_q;
                act_user1_q <= user1_q;
            end
        end
    end

    // read data launched on falling edge so host samples on rising edge
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_sdio_oe <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
        end else if (state_q == ST_RD) begin
            o_sdio_oe <= ~config_q[spcr_pkg::BIT_DIR];
            o_serial_out_pin_oe <= config_q[spcr_pkg::BIT_DIR];
        end else begin
            o_sdio_oe <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
        end
    end

    logic [2:0] pos;
    logic rd_bit;
    assign pos = lsb_eff ? cnt_q[2:0] : 3'h7 - cnt_q[2:0];
    assign rd_bit = rd_byte[pos];

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_sdio <= 1'b0;
            o_serial_out_pin <= 1'b0;
        end else begin
            o_sdio <= rd_bit;
            o_serial_out_pin <= rd_bit;
        end
    end

    // status toward the core clock, two flops per level
    logic [1:0] dir_s_q;
    logic [1:0] lsb_s_q;
    logic [1:0] busy_s_q;
    logic [7:0] u0_a_q;
    logic [7:0] u0_b_q;
    logic [7:0] u0_c_q;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dir_s_q <= 2'h0;
            lsb_s_q <= 2'h0;
            busy_s_q <= 2'h0;
            u0_a_q <= 8'h00;
            u0_b_q <= 8'h00;
            u0_c_q <= 8'h00;
            o_direction_select_bit <= 1'b0;
            o_lsb_first <= 1'b0;
            o_busy <= 1'b0;
            o_active_user0 <= 8'h00;
        end else begin
            dir_s_q <= {dir_s_q[0], config_q[spcr_pkg::BIT_DIR]};
            lsb_s_q <= {lsb_s_q[0], lsb_eff};
            busy_s_q <= {busy_s_q[0], ~i_cs_n};
            u0_a_q <= act_user0_q;
            u0_b_q <= u0_a_q;
            u0_c_q <= u0_b_q;
            o_direction_select_bit <= dir_s_q[1];
            o_lsb_first <= lsb_s_q[1];
            o_busy <= busy_s_q[1];
            // slow-changing word; sampled twice equal before use
            if (u0_c_q == u0_b_q) begin
                o_active_user0 <= u0_c_q;
            end
        end
    end

    // link-side checks; reset cuts any attempt short, chip select only the frame and pin checks
    // pin checks sample at rising sclk, half a period after the bit launched

    sequence soft_wr_s;
        wr_done && addr_q == spcr_pkg::ADDR_CONFIG && wr_byte[spcr_pkg::BIT_SOFT_RESET];
    endsequence
    sequence soft_clr_s;
        soft_pend_q ##1 !config_q[spcr_pkg::BIT_SOFT_RESET];
    endsequence

    // soft reset: pending flag, self clear, register defaults
    soft_seq_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        soft_wr_s |=> soft_clr_s)
        else $error("soft reset sequence broken");
    softclr_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        soft_pend_q |=> !config_q[spcr_pkg::BIT_SOFT_RESET] || $past(wr_done))
        else $error("soft reset bit did not self clear");
    mirror_clr_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        soft_pend_q |=> !config_q[7 - spcr_pkg::BIT_SOFT_RESET] || $past(wr_done))
        else $error("soft reset mirror bit did not clear");
    softrst_keep_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        soft_pend_q |=> readback_q == 8'h00 && user0_q == 8'h00)
        else $error("soft reset left register set");
    cfg_keep_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        (soft_pend_q && !wr_done) |=> config_q[7:6] == $past(config_q[7:6]))
        else $error("soft reset disturbed port configuration");

    // address stepping per byte, order bit and i2c override
    addr_dec_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        (state_q == ST_WR && cnt_q == 5'h07 && !lsb_eff) |=> addr_q == $past(addr_q) - 13'h1)
        else $error("address not decremented");
    addr_inc_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        (state_q == ST_WR && cnt_q == 5'h07 && lsb_eff) |=> addr_q == $past(addr_q) + 13'h1)
        else $error("address not incremented");
    i2c_order_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        (i2c_sync_q[1] && state_q == ST_RD) |-> pos == 3'h7 - cnt_q[2:0])
        else $error("bit order honoured in i2c mode");
    i2c_addr_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        (i2c_sync_q[1] && state_q == ST_WR && cnt_q == 5'h07) |=> addr_q == $past(addr_q) - 13'h1)
        else $error("address not decremented in i2c mode");

    logic rd_3w;
    logic rd_4w;
    assign rd_3w = (state_q == ST_RD) && !config_q[spcr_pkg::BIT_DIR];
    assign rd_4w = (state_q == ST_RD) && config_q[spcr_pkg::BIT_DIR];
    // read path: pin selection, launched bit, bank selection
    rd_pin_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        rd_3w |-> o_sdio_oe && o_sdio == rd_byte[pos])
        else $error("read bit missing on data pin");
    out_float_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        rd_3w |-> !o_serial_out_pin_oe)
        else $error("output pin driven in three wire mode");
    rd_out_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        rd_4w |-> o_serial_out_pin_oe && o_serial_out_pin == rd_byte[pos])
        else $error("read bit missing on output pin");
    sdio_free_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        rd_4w |-> !o_sdio_oe)
        else $error("data pin driven in four wire mode");
    variant_ro_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        addr_q == spcr_pkg::ADDR_VARIANT |-> rd_byte == VARIANT)
        else $error("variant identifier changed");
    readback_sel_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        (addr_q == spcr_pkg::ADDR_USER0 && readback_q[0]) |-> rd_byte == act_user0_q)
        else $error("active register not returned");
    buffer_sel_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        (addr_q == spcr_pkg::ADDR_USER0 && !readback_q[0]) |-> rd_byte == user0_q)
        else $error("buffer register not returned");

    // active copies move only on an update, a soft reset or the link reset
    update_copy_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        (upd_sync_q[2] != upd_sync_q[1] && !soft_pend_q) |=> act_user0_q == $past(user0_q))
        else $error("active register not loaded on update");
    active_hold_a: assert property (@(posedge i_sclk) disable iff (link_rst)
        (upd_sync_q[2] == upd_sync_q[1] && !soft_pend_q) |=> act_user0_q == $past(act_user0_q))
        else $error("active register changed without update");

    hdr_state_a: assert property (@(posedge i_sclk) disable iff (link_rst || i_cs_n)
        (state_q == ST_HDR && cnt_q == 5'h0f) |=> state_q == ($past(hdr_q[14]) ? ST_RD : ST_WR))
        else $error("header direction bit not decoded");
endmodule

//--- spcr_pkg.sv
// constants for the serial port configuration register block
// How it works
// - direction bit low: data pin carries reads and writes, output pin floats
// - direction bit high: writes on data pin, reads driven on output pin
// - order bit low: msb first, address decrements per byte
// - order bit high: lsb first, address increments per byte
// - bit order ignored when the port runs in i2c mode
// - soft reset restores all registers to defaults except port configuration
// - soft reset bit clears itself one serial clock after the write ends
// - read-only eight bit silicon revision register
// - read-only eight bit variant identifier, writes ignored
// - readback bit low: reads return buffer registers
// - readback bit high: reads return active registers
package spcr_pkg;
    localparam logic [12:0] ADDR_CONFIG = 13'h0000;
    localparam logic [12:0] ADDR_REVISION = 13'h0002;
    localparam logic [12:0] ADDR_VARIANT = 13'h0003;
    localparam logic [12:0] ADDR_READBACK = 13'h0004;
    localparam logic [12:0] ADDR_USER0 = 13'h0005;
    localparam logic [12:0] ADDR_USER1 = 13'h0006;
    localparam int BIT_DIR = 7;
    localparam int BIT_LSB_FIRST = 6;
    localparam int BIT_SOFT_RESET = 5;
    localparam int BIT_READBACK = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] READBACK_RESET = 8'h00;
    localparam logic [7:0] USER_RESET = 8'h00;
    localparam int ADDR_W = 13;
    localparam int HDR_BITS = 16;
endpackage

//--- spcr_host_model.sv
// host spi controller model driving serial clock, chip select and data wire
`timescale 1ns/100ps
module spcr_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdio,
    input wire logic i_sdio,
    input wire logic i_sdio_oe,
    input wire logic i_so,
    input wire logic i_so_oe
);
    logic run = 1'b1;
    logic drv = 1'b1;
    logic mosi = 1'b0;
    logic last = 1'b0;
    // a released wire shows the inverse of its last level, never a steady guess
    assign o_sdio = drv ? mosi : (i_sdio_oe ? i_sdio : ~last);
    always @(negedge o_sclk) last <= o_sdio;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        #3;
        // clock stops low outside frames once reset is over
        forever begin
            #16;
            if (run || o_sclk) o_sclk = ~o_sclk;
        end
    end
    task automatic xfer(input bit rd, input logic [12:0] a, input int n, input bit lsb,
                        input bit fw, input logic [15:0] wd, output logic [15:0] q);
        logic [15:0] hdr;
        int k;
        hdr = {rd, 2'b00, a};
        q = 16'h0000;
        run = 1'b1;
        @(negedge o_sclk);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = hdr[i];
            @(negedge o_sclk);
        end
        for (int j = 0; j < 8 * n; j++) begin
            k = 8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8);
            drv = !rd;
            mosi = wd[k];
            @(posedge o_sclk);
            q[k] = fw ? (i_so_oe ? i_so : ~last) : o_sdio;
            @(negedge o_sclk);
        end
        drv = 1'b1;
        o_cs_n = 1'b1;
        // trailing cycles let self-clearing bits settle
        repeat (2) @(negedge o_sclk);
        run = 1'b0;
    endtask
endmodule

//--- test_serial_port_config_regs.sv
// self-checking bench for the serial port configuration registers
`timescale 1ns/100ps
module test_serial_port_config_regs;
    localparam logic [7:0] REV = 8'h11;  // arbitrary value
    localparam logic [7:0] VAR = 8'h5a;  // arbitrary value
    logic clk;
    logic rst = 1'b1;
    logic i2c = 1'b0;
    logic upd = 1'b0;
    logic sclk, cs_n, sdio_w, sdio, sdio_oe, so, so_oe, dir, lsbf, busy;
    logic [7:0] act0;
    logic [15:0] q;
    logic so_seen = 1'b0;
    logic sd_seen = 1'b0;
    logic busy_seen = 1'b0;
    int fails = 0;
    int compares = 0;
    spcr_top #(.REVISION(REV), .VARIANT(VAR)) u_dut (.i_core_clk(clk), .i_rst(rst),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio_w), .i_i2c_mode(i2c), .i_update(upd),
        .o_sdio(sdio), .o_sdio_oe(sdio_oe), .o_serial_out_pin(so),
        .o_serial_out_pin_oe(so_oe), .o_direction_select_bit(dir), .o_lsb_first(lsbf),
        .o_active_user0(act0), .o_busy(busy));
    spcr_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio_w), .i_sdio(sdio),
        .i_sdio_oe(sdio_oe), .i_so(so), .i_so_oe(so_oe));
    always @(posedge sclk) begin
        if (so_oe === 1'b1) so_seen <= 1'b1;
        if (sdio_oe === 1'b1) sd_seen <= 1'b1;
    end
    always @(posedge clk) begin
        if (busy === 1'b1) busy_seen <= 1'b1;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [12:0] a, input int n, input bit lsb, input logic [15:0] d);
        u_host.xfer(1'b0, a, n, lsb, 1'b0, d, q);
    endtask
    task automatic rd(input string nm, input logic [12:0] a, input bit lsb, input bit fw,
                      input logic [7:0] exp);
        u_host.xfer(1'b1, a, 1, lsb, fw, 16'h0000, q);
        check(nm, q[7:0], exp);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // all frames together need well under this span
    initial begin
        #500000;
        fails++;
        final_report;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd("config", spcr_pkg::ADDR_CONFIG, 0, 0, 8'h00);
        rd("readback", spcr_pkg::ADDR_READBACK, 0, 0, 8'h00);
        wr(spcr_pkg::ADDR_REVISION, 1, 0, 16'h00ff);
        wr(spcr_pkg::ADDR_VARIANT, 1, 0, 16'h00ff);
        rd("revision", spcr_pkg::ADDR_REVISION, 0, 0, REV);
        rd("variant", spcr_pkg::ADDR_VARIANT, 0, 0, VAR);
        rd("unmapped", 13'h0010, 0, 0, 8'h00);
        $display("test reset_and_identity done");
        wr(spcr_pkg::ADDR_USER0, 1, 0, 16'h00a5);
        rd("user0 buffer", spcr_pkg::ADDR_USER0, 0, 0, 8'ha5);
        check("active before update", act0, 8'h00);
        wr(spcr_pkg::ADDR_READBACK, 1, 0, 16'h0001);
        rd("user0 active", spcr_pkg::ADDR_USER0, 0, 0, 8'h00);
        @(negedge clk);
        upd = ~upd;
        // the update is sampled on sclk, so a frame must run before it lands
        rd("user0 active new", spcr_pkg::ADDR_USER0, 0, 0, 8'ha5);
        for (int i = 0; i < 32 && act0 !== 8'ha5; i++) @(negedge clk);
        check("active after update", act0, 8'ha5);
        $display("test readback_select done");
        wr(spcr_pkg::ADDR_READBACK, 1, 0, 16'h0000);
        wr(spcr_pkg::ADDR_USER1, 2, 0, 16'h6677);
        rd("msb first 0x6", spcr_pkg::ADDR_USER1, 0, 0, 8'h77);
        rd("msb first 0x5", spcr_pkg::ADDR_USER0, 0, 0, 8'h66);
        check("out pin enable 3w", {7'h00, so_seen}, 8'h00);
        check("data pin enable 3w", {7'h00, sd_seen}, 8'h01);
        $display("test msb_first done");
        wr(spcr_pkg::ADDR_CONFIG, 1, 0, 16'h0042);
        for (int i = 0; i < 32 && lsbf !== 1'b1; i++) @(negedge clk);
        check("lsb first level", {7'h00, lsbf}, 8'h01);
        wr(spcr_pkg::ADDR_USER0, 2, 1, 16'h3412);
        rd("lsb first 0x5", spcr_pkg::ADDR_USER0, 1, 0, 8'h12);
        rd("lsb first 0x6", spcr_pkg::ADDR_USER1, 1, 0, 8'h34);
        i2c = 1'b1;
        repeat (8) @(negedge clk);
        rd("i2c order", spcr_pkg::ADDR_USER0, 0, 0, 8'h12);
        wr(spcr_pkg::ADDR_USER1, 2, 0, 16'h9c5e);
        rd("i2c order 0x6", spcr_pkg::ADDR_USER1, 0, 0, 8'h5e);
        rd("i2c order 0x5", spcr_pkg::ADDR_USER0, 0, 0, 8'h9c);
        i2c = 1'b0;
        repeat (8) @(negedge clk);
        $display("test lsb_first done");
        wr(spcr_pkg::ADDR_CONFIG, 1, 1, 16'h00c3);
        so_seen = 1'b0;
        sd_seen = 1'b0;
        rd("variant 4w", spcr_pkg::ADDR_VARIANT, 1, 1, VAR);
        check("out pin enable 4w", {7'h00, so_seen}, 8'h01);
        check("data pin enable 4w", {7'h00, sd_seen}, 8'h00);
        check("direction level", {7'h00, dir}, 8'h01);
        $display("test four_wire done");
        wr(spcr_pkg::ADDR_READBACK, 1, 1, 16'h0001);
        wr(spcr_pkg::ADDR_CONFIG, 1, 1, 16'h00e7);
        rd("config kept", spcr_pkg::ADDR_CONFIG, 1, 1, 8'hc3);
        rd("readback cleared", spcr_pkg::ADDR_READBACK, 1, 1, 8'h00);
        rd("user0 cleared", spcr_pkg::ADDR_USER0, 1, 1, 8'h00);
        for (int i = 0; i < 16 && busy !== 1'b0; i++) @(negedge clk);
        check("busy seen", {7'h00, busy_seen}, 8'h01);
        check("busy idle", {7'h00, busy}, 8'h00);
        $display("test soft_reset done");
        final_report;
    end
endmodule
